// ===== verilog/bmss_defines.svh
// Constants for the boot mode strap selector
`ifndef BMSS_DEFINES_SVH
`define BMSS_DEFINES_SVH

`define BMSS_ADDR_W          32
`define BMSS_VEC_PFLASH      32'hFFFF_FFFC
`define BMSS_VEC_BOOT_ROM    32'hFF7F_C000
`define BMSS_VEC_USB_FLASH   32'hFFFF_C000
`define BMSS_USB_FLASH_KB    16
`define BMSS_USB_POWER_MA    500
`define BMSS_USB_POWER_UNITS 8'hFA
// Identity codes below are arbitrary values
`define BMSS_MAKER_VID       16'h1A2B
`define BMSS_MAKER_PID_BASE  16'h0010
`define BMSS_STD_VID         16'h3C4D
`define BMSS_STD_PID         16'h0042

`endif

// ===== verilog/bmss_pkg.sv
// Types for the boot mode strap selector
`default_nettype none
package bmss_pkg;
  typedef enum logic [1:0] {
    BMSS_MODE_NORMAL,
    BMSS_MODE_ROM,
    BMSS_MODE_USB
  } bmss_mode_t;

  typedef struct packed {
    logic        valid;
    logic        bus_powered;
    logic [7:0]  max_power;
    logic [15:0] vendor_id;
    logic [15:0] product_id;
  } bmss_usb_desc_t;
endpackage
`default_nettype wire

// ===== verilog/bmss_top.sv
// Boot mode strap selector: samples straps at reset release, picks start vector
`timescale 1ns/1ps
`default_nettype none
`include "bmss_defines.svh"

module bmss_top (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     boot_select_line_i,
  input  wire logic                     boot_select_driven_i,
  input  wire logic                     boot_switch_pole_i,
  input  wire logic                     boot_variant_strap_i,
  input  wire logic                     boot_variant_driven_i,
  input  wire logic                     maker_firmware_i,
  input  wire logic [7:0]               protocol_version_i,
  input  wire logic                     power_report_sense_pin_i,
  output logic                          mode_valid_o,
  output bmss_pkg::bmss_mode_t          boot_mode_o,
  output logic [`BMSS_ADDR_W-1:0]       start_addr_o,
  output logic                          variant_gpio_free_o,
  output bmss_pkg::bmss_usb_desc_t      usb_desc_o
);

  logic                 boot_select_strap;
  logic                 variant_level;
  logic                 sampled_r;
  bmss_pkg::bmss_mode_t mode_nxt;
  logic [`BMSS_ADDR_W-1:0] addr_nxt;

  // Weak pull-ups win when undriven; closed pole wins over the select line, not the variant strap
  assign boot_select_strap = boot_switch_pole_i ? 1'b0 :
                             (boot_select_driven_i ? boot_select_line_i : 1'b1);
  assign variant_level     = boot_variant_driven_i ? boot_variant_strap_i : 1'b1;

  always_comb begin
    if (boot_select_strap) begin
      mode_nxt = bmss_pkg::BMSS_MODE_NORMAL;
      addr_nxt = `BMSS_VEC_PFLASH;
    end else if (!variant_level) begin
      mode_nxt = bmss_pkg::BMSS_MODE_ROM;
      addr_nxt = `BMSS_VEC_BOOT_ROM;
    end else begin
      mode_nxt = bmss_pkg::BMSS_MODE_USB;
      addr_nxt = `BMSS_VEC_USB_FLASH;
    end
  end

  // Sample once on the first edge after reset release, then hold
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sampled_r    <= 1'b0;
      mode_valid_o <= 1'b0;
      boot_mode_o  <= bmss_pkg::BMSS_MODE_NORMAL;
      start_addr_o <= `BMSS_VEC_PFLASH;
    end else if (!sampled_r) begin
      sampled_r    <= 1'b1;
      mode_valid_o <= 1'b1;
      boot_mode_o  <= mode_nxt;
      start_addr_o <= addr_nxt;
    end
  end

  // Variant pin free for general use only in normal boot
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      variant_gpio_free_o <= 1'b0;
    end else if (!sampled_r) begin
      variant_gpio_free_o <= (mode_nxt == bmss_pkg::BMSS_MODE_NORMAL);
    end
  end

  // USB identity report in USB boot
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      usb_desc_o <= '0;
    end else if (mode_valid_o && boot_mode_o == bmss_pkg::BMSS_MODE_USB) begin
      if (maker_firmware_i) begin
        usb_desc_o.valid       <= 1'b1;
        usb_desc_o.bus_powered <= 1'b1;
        usb_desc_o.max_power   <= `BMSS_USB_POWER_UNITS;
        usb_desc_o.vendor_id   <= `BMSS_MAKER_VID;
        usb_desc_o.product_id  <= `BMSS_MAKER_PID_BASE + {8'h00, protocol_version_i};
      end else if (power_report_sense_pin_i) begin
        usb_desc_o.valid       <= 1'b1;
        usb_desc_o.bus_powered <= 1'b1;
        usb_desc_o.max_power   <= `BMSS_USB_POWER_UNITS;
        usb_desc_o.vendor_id   <= `BMSS_STD_VID;
        usb_desc_o.product_id  <= `BMSS_STD_PID;
      end else begin
        usb_desc_o <= '0;
      end
    end else begin
      usb_desc_o <= '0;
    end
  end

  AST_MODE_HELD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mode_valid_o |=> $stable(boot_mode_o) && $stable(start_addr_o))
    else $error("boot mode changed after latch");

  AST_NORMAL_VEC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!sampled_r && boot_select_strap) |=>
      boot_mode_o == bmss_pkg::BMSS_MODE_NORMAL && start_addr_o == `BMSS_VEC_PFLASH)
    else $error("normal boot not selected");

  AST_ROM_VEC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!sampled_r && !boot_select_strap && !variant_level) |=>
      boot_mode_o == bmss_pkg::BMSS_MODE_ROM && start_addr_o == `BMSS_VEC_BOOT_ROM)
    else $error("rom boot not selected");

  AST_USB_VEC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!sampled_r && !boot_select_strap && variant_level) |=>
      boot_mode_o == bmss_pkg::BMSS_MODE_USB && start_addr_o == `BMSS_VEC_USB_FLASH)
    else $error("usb boot not selected");

  AST_VALID_ONCE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !sampled_r |=> mode_valid_o ##1 mode_valid_o)
    else $error("mode not valid after first edge");

  AST_GPIO_FREE: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mode_valid_o |-> variant_gpio_free_o == (boot_mode_o == bmss_pkg::BMSS_MODE_NORMAL))
    else $error("variant pin release wrong");

  AST_DEFAULT_NORMAL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!sampled_r && !boot_select_driven_i && !boot_switch_pole_i) |=>
      boot_mode_o == bmss_pkg::BMSS_MODE_NORMAL)
    else $error("undriven straps did not boot normally");

  AST_SWITCH_USB: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!sampled_r && boot_switch_pole_i && !boot_variant_driven_i) |=>
      boot_mode_o == bmss_pkg::BMSS_MODE_USB)
    else $error("switch pole did not give usb boot");

  AST_MAKER_DESC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mode_valid_o && boot_mode_o == bmss_pkg::BMSS_MODE_USB && maker_firmware_i) |=>
      usb_desc_o.valid && usb_desc_o.vendor_id == `BMSS_MAKER_VID &&
      usb_desc_o.max_power == `BMSS_USB_POWER_UNITS)
    else $error("maker usb report wrong");

  AST_STD_DESC: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mode_valid_o && boot_mode_o == bmss_pkg::BMSS_MODE_USB && !maker_firmware_i) |=>
      usb_desc_o.valid == $past(power_report_sense_pin_i))
    else $error("standard usb report wrong");

  // Reset values are checked one edge later, once the flops have settled
  AST_RESET_STATE: assert property (@(posedge ref_clk_i)
    !rst_n_i |=> !mode_valid_o && !variant_gpio_free_o && !usb_desc_o.valid &&
      boot_mode_o == bmss_pkg::BMSS_MODE_NORMAL && start_addr_o == `BMSS_VEC_PFLASH)
    else $error("reset state wrong");

  AST_VALID_STAYS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mode_valid_o |=> mode_valid_o)
    else $error("mode valid dropped without reset");

  AST_GPIO_HELD: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mode_valid_o |=> $stable(variant_gpio_free_o))
    else $error("variant pin release changed after latch");

  AST_VEC_MATCH: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    mode_valid_o |->
      (boot_mode_o == bmss_pkg::BMSS_MODE_NORMAL && start_addr_o == `BMSS_VEC_PFLASH) ||
      (boot_mode_o == bmss_pkg::BMSS_MODE_ROM && start_addr_o == `BMSS_VEC_BOOT_ROM) ||
      (boot_mode_o == bmss_pkg::BMSS_MODE_USB && start_addr_o == `BMSS_VEC_USB_FLASH))
    else $error("start vector does not match mode");

  // Strap decode seen from the pins
  AST_SELECT_HIGH: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!sampled_r && boot_select_driven_i && boot_select_line_i && !boot_switch_pole_i) |=>
      boot_mode_o == bmss_pkg::BMSS_MODE_NORMAL && variant_gpio_free_o)
    else $error("driven select high did not boot normally");

  AST_VARIANT_DEFAULT: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!sampled_r && !boot_select_strap && !boot_variant_driven_i) |=>
      boot_mode_o == bmss_pkg::BMSS_MODE_USB && start_addr_o == `BMSS_VEC_USB_FLASH)
    else $error("undriven variant did not give usb boot");

  AST_POLE_SPECIAL: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!sampled_r && boot_switch_pole_i) |=>
      boot_mode_o != bmss_pkg::BMSS_MODE_NORMAL && !variant_gpio_free_o)
    else $error("closed pole gave normal boot");

  // Identity report
  AST_MAKER_PID: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mode_valid_o && boot_mode_o == bmss_pkg::BMSS_MODE_USB && maker_firmware_i) |=>
      usb_desc_o.bus_powered &&
      usb_desc_o.product_id == `BMSS_MAKER_PID_BASE + {8'h00, $past(protocol_version_i)})
    else $error("maker usb product id wrong");

  AST_STD_IDS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mode_valid_o && boot_mode_o == bmss_pkg::BMSS_MODE_USB && !maker_firmware_i &&
      power_report_sense_pin_i) |=> usb_desc_o.bus_powered &&
      usb_desc_o.max_power == `BMSS_USB_POWER_UNITS && usb_desc_o.vendor_id == `BMSS_STD_VID &&
      usb_desc_o.product_id == `BMSS_STD_PID)
    else $error("standard usb report ids wrong");

  AST_STD_SENSE_LOW: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mode_valid_o && boot_mode_o == bmss_pkg::BMSS_MODE_USB && !maker_firmware_i &&
      !power_report_sense_pin_i) |=> usb_desc_o == '0)
    else $error("standard usb report shown with sense low");

  AST_DESC_USB_ONLY: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (mode_valid_o && boot_mode_o != bmss_pkg::BMSS_MODE_USB) |=> !usb_desc_o.valid)
    else $error("usb report outside usb boot");

  AST_DESC_WAITS: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !mode_valid_o |=> !usb_desc_o.valid)
    else $error("usb report before mode latched");

endmodule // bmss_top
`default_nettype wire

// ===== tb/bmss_strap_host.sv
// Fixture model that drives the strap pins of the boot mode strap selector
`timescale 1ns/1ps
`default_nettype none
module bmss_strap_host (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic sel_drive_i,
  input  wire logic sel_level_i,
  input  wire logic pole_i,
  input  wire logic var_drive_i,
  input  wire logic var_level_i,
  output logic      sel_line_o,
  output logic      sel_driven_o,
  output logic      var_line_o,
  output logic      var_driven_o
);
  logic var_drive_r;
  logic var_level_r;

  // Variant strap only changes while reset is held
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      var_drive_r <= var_drive_i;
      var_level_r <= var_level_i;
    end
  end

  // Closed pole wins, select is then not driven; released lines sit at pull-up level
  assign sel_driven_o = sel_drive_i & ~pole_i;
  assign sel_line_o   = sel_driven_o ? sel_level_i : 1'b1;
  assign var_driven_o = var_drive_r;
  assign var_line_o   = var_drive_r ? var_level_r : 1'b1;
endmodule // bmss_strap_host
`default_nettype wire

// ===== tb/boot_mode_strap_select_test.sv
// Self-checking bench for the boot mode strap selector
`timescale 1ns/1ps
`default_nettype none
`include "bmss_defines.svh"
module boot_mode_strap_select_test;
  logic ref_clk = 1'b0, rst_n = 1'b0, sel_drive = 1'b0, sel_level = 1'b0, pole = 1'b0;
  logic var_drive = 1'b0, var_level = 1'b0, maker_fw = 1'b0, sense = 1'b0;
  logic [7:0] version = 8'h00;
  logic sel_line, sel_driven, var_line, var_driven, mode_valid, gpio_free;
  logic [31:0] start_addr;
  bmss_pkg::bmss_mode_t     mode;
  bmss_pkg::bmss_usb_desc_t desc;
  int n_errors = 0;
  int cmp_count = 0;

  always #50 ref_clk = ~ref_clk;

  bmss_strap_host host (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .sel_drive_i(sel_drive),
    .sel_level_i(sel_level), .pole_i(pole), .var_drive_i(var_drive), .var_level_i(var_level),
    .sel_line_o(sel_line), .sel_driven_o(sel_driven), .var_line_o(var_line),
    .var_driven_o(var_driven));
  bmss_top uut (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .boot_select_line_i(sel_line),
    .boot_select_driven_i(sel_driven), .boot_switch_pole_i(pole),
    .boot_variant_strap_i(var_line), .boot_variant_driven_i(var_driven),
    .maker_firmware_i(maker_fw), .protocol_version_i(version),
    .power_report_sense_pin_i(sense), .mode_valid_o(mode_valid), .boot_mode_o(mode),
    .start_addr_o(start_addr), .variant_gpio_free_o(gpio_free), .usb_desc_o(desc));

  task automatic stop_test;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check_vec(input string what, input logic [47:0] exp, input logic [47:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_mode(input string what, input bmss_pkg::bmss_mode_t exp, got);
    check_vec(what, {46'h0, exp}, {46'h0, got});
  endtask
  // Straps are set during a 16 cycle reset, results read after release
  task automatic boot(input logic sd, sl, p, vd, vl);
    @(posedge ref_clk);
    rst_n <= 1'b0; sel_drive <= sd; sel_level <= sl; pole <= p; var_drive <= vd; var_level <= vl;
    repeat (16) @(posedge ref_clk);
    check_vec("valid in reset", 48'h0, {47'h0, mode_valid});
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic expect_boot(input bmss_pkg::bmss_mode_t m, input logic [31:0] a, input logic f);
    check_vec("valid", 48'h1, {47'h0, mode_valid});
    check_mode("mode", m, mode);
    check_vec("start", {16'h0, a}, {16'h0, start_addr});
    check_vec("gpio free", {47'h0, f}, {47'h0, gpio_free});
  endtask

  task automatic t_pullups;
    boot(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    expect_boot(bmss_pkg::BMSS_MODE_NORMAL, `BMSS_VEC_PFLASH, 1'b1);
    check_vec("desc valid", 48'h0, {47'h0, desc.valid});
  endtask
  task automatic t_sel_high;
    boot(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    expect_boot(bmss_pkg::BMSS_MODE_NORMAL, `BMSS_VEC_PFLASH, 1'b1);
  endtask
  task automatic t_rom;
    boot(1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    expect_boot(bmss_pkg::BMSS_MODE_ROM, `BMSS_VEC_BOOT_ROM, 1'b0);
    @(posedge ref_clk);
    sel_level <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    check_mode("mode after select change", bmss_pkg::BMSS_MODE_ROM, mode);
  endtask
  task automatic t_usb_maker;
    logic [47:0] exp_desc;
    logic [47:0] got_desc;
    exp_desc = {6'h0, 2'h3, `BMSS_USB_POWER_UNITS, `BMSS_MAKER_VID,
      `BMSS_MAKER_PID_BASE + 16'h0005};
    @(posedge ref_clk);
    maker_fw <= 1'b1;
    version  <= 8'h05;
    boot(1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
    expect_boot(bmss_pkg::BMSS_MODE_USB, `BMSS_VEC_USB_FLASH, 1'b0);
    got_desc = {6'h0, desc.valid, desc.bus_powered, desc.max_power, desc.vendor_id,
      desc.product_id};
    check_vec("maker desc", exp_desc, got_desc);
    @(posedge ref_clk);
    version <= 8'h07;
    repeat (2) @(posedge ref_clk);
    #1;
    check_vec("maker pid", {32'h0, `BMSS_MAKER_PID_BASE + 16'h0007}, {32'h0, desc.product_id});
  endtask
  task automatic t_usb_std;
    logic [47:0] exp_desc;
    logic [47:0] got_desc;
    exp_desc = {6'h0, 2'h3, `BMSS_USB_POWER_UNITS, `BMSS_STD_VID, `BMSS_STD_PID};
    @(posedge ref_clk);
    maker_fw <= 1'b0;
    sense    <= 1'b1;
    boot(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    expect_boot(bmss_pkg::BMSS_MODE_USB, `BMSS_VEC_USB_FLASH, 1'b0);
    got_desc = {6'h0, desc.valid, desc.bus_powered, desc.max_power, desc.vendor_id,
      desc.product_id};
    check_vec("std desc", exp_desc, got_desc);
    @(posedge ref_clk);
    sense <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    check_vec("desc valid sense low", 48'h0, {47'h0, desc.valid});
  endtask

  initial begin
    #200000;
    n_errors++;
    stop_test;
  end
  initial begin
    t_pullups;
    t_sel_high;
    t_rom;
    t_usb_maker;
    t_usb_std;
    stop_test;
  end
endmodule // boot_mode_strap_select_test
`default_nettype wire
